// >>> hw/sst_pkg.sv
/*
  constants and types of the status and self-test block.
  assumes a front end that splits host text into command and mask chars.
*/
package sst_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 40000000; // system clock rate
  localparam int unsigned FPAN_TIMEOUT_S = 10; // key wait, seconds
  localparam int unsigned FPAN_TIMEOUT_CYC = FPAN_TIMEOUT_S * CLK_HZ;

  // ==========================================================
  // status summary byte field positions
  localparam int MAV_BIT = 4; // message available
  localparam int ESB_BIT = 5; // event status summary
  localparam int MSS_BIT = 6; // master summary status
  localparam logic [7:0] SRE_RESET = 8'h00; // enable mask after reset
  localparam logic [7:0] SRE_WRITABLE = 8'hbf; // bit 6 always reads zero

  // ==========================================================
  // card selection
  localparam int NUM_CARDS = 4;
  localparam logic [2:0] CARD_ALL = 3'h0; // selector code for every card
  localparam logic [2:0] CARD_MAX = 3'h4; // highest card number

  // ==========================================================
  // ascii codes
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_Q = 8'h51;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_NL = 8'h0a;

  // ==========================================================
  // commands, results, test kinds
  typedef enum logic [3:0] {
    OP_STB_Q, OP_SRE_SET, OP_SRE_Q, OP_TST_Q, OP_WAI,
    OP_CARD_CLEAR, OP_CARD_EXEC_Q, OP_CARD_STATE_Q,
    OP_FRAME_CLEAR, OP_FRAME_EXEC_Q, OP_FRAME_STATE_Q
  } sst_op_t;

  typedef enum logic [1:0] {RES_NONE, RES_PASS, RES_FAIL} sst_res_t;

  typedef enum logic [1:0] {KIND_SELF, KIND_CARD, KIND_CTRL} sst_kind_t;

  typedef struct packed {
    sst_op_t op; // command to run
    logic [2:0] card; // 0 = all, 1..4 = one card
    logic frame_fpan; // frame test select: 1 = front panel, 0 = controller
  } sst_cmd_t;

  typedef struct packed {
    sst_kind_t kind; // which external test engine runs
    logic [NUM_CARDS-1:0] cards; // cards under test
  } sst_test_t;

endpackage : sst_pkg

// >>> hw/sst_core.sv
/*
  status and self-test command interpreter with stored test results.
  assumes external test engines and a host that takes answers by ready.
*/
`timescale 1ns/100ps
// ==========================================================
// Overview of operation
// - status byte bit 6 is master summary
// - bits 4, 5 live; others read zero
// - answers are decimal text, newline with end
// - mask accepted in four radixes, same bits
// - self-test query answers 0 pass, 1 fail
// - self-test leaves device in reset state
// - wait stalls commands until operation complete
// - card clear and card test take card 1 to 4 or all; card result query takes 1 to 4 only
// - card clear erases selected card results
// - card test answers 1 if any fails
// - card test restores card power-on settings
// - card result: 1 fail, 0 pass, -1 untested
// - frame clear erases selected frame result
// - controller test requests device reset as its answer starts
// - front-panel test leaves state unchanged
// - front-panel test fails without key in time
// - frame result: 1 fail, 0 pass, -1 untested
// - master summary ORs enabled status bits
module sst_core #(
  parameter int unsigned FPAN_TIMEOUT = sst_pkg::FPAN_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i, // decoded command offered
  input wire sst_pkg::sst_cmd_t cmd_i,
  output logic cmd_ready_o, // command taken when high with valid
  input wire logic param_valid_i, // mask text character offered
  input wire logic [7:0] param_char_i,
  output logic resp_valid_o, // response character offered
  output logic [7:0] resp_char_o,
  output logic resp_end_o, // marks the closing newline
  input wire logic resp_ready_i,
  input wire logic esb_i, // event status summary from the event block
  input wire logic opc_i, // no operation pending
  input wire logic key_i, // front-panel key, asynchronous pin
  output logic test_start_o, // one-cycle start of an engine test
  output sst_pkg::sst_test_t test_o,
  input wire logic test_done_i,
  input wire logic test_fail_i, // self or controller verdict
  input wire logic [sst_pkg::NUM_CARDS-1:0] card_fail_i, // per-card verdict
  output logic inst_reset_o, // one-cycle instrument reset request
  output logic card_cpon_o, // one-cycle power-on settings request
  output logic [sst_pkg::NUM_CARDS-1:0] card_cpon_mask_o,
  output logic [7:0] status_summary_byte_o, // live status byte
  output logic cmd_error_o // one-cycle: bad card selector
);

  // ==========================================================
  // helpers
  // value of a digit in the given radix, or 5'h1f when not a digit
  function automatic logic [4:0] digit_val(input logic [7:0] c, input logic [4:0] radix);
    logic [4:0] v;
    v = 5'h1f;
    if (c >= sst_pkg::CH_0 && c <= sst_pkg::CH_9)
      v = 5'(c - sst_pkg::CH_0);
    else if (c >= sst_pkg::CH_A && c <= sst_pkg::CH_F)
      v = 5'(c - sst_pkg::CH_A + 8'h0a);
    if (v >= radix)
      v = 5'h1f;
    return v;
  endfunction : digit_val

  // card selector to mask; zero mask means an illegal selector
  function automatic logic [sst_pkg::NUM_CARDS-1:0] card_mask(input logic [2:0] sel,
                                                              input logic allow_all);
    logic [sst_pkg::NUM_CARDS-1:0] m;
    m = '0;
    if (sel == sst_pkg::CARD_ALL)
      m = allow_all ? '1 : '0;
    else if (sel <= sst_pkg::CARD_MAX)
      m = sst_pkg::NUM_CARDS'(1) << (sel - 3'h1);
    return m;
  endfunction : card_mask

  // ==========================================================
  // state
  typedef enum {ST_IDLE, ST_WAIT_OPC, ST_TEST, ST_FPAN, ST_RESP} sst_state_t;
  sst_state_t state; // main sequencer
  sst_pkg::sst_cmd_t cmd_q; // command under execution
  logic [7:0] sre; // service-request enable mask
  sst_pkg::sst_res_t card_res [sst_pkg::NUM_CARDS]; // stored relay results
  sst_pkg::sst_res_t ctrl_res; // controller test result
  sst_pkg::sst_res_t fpan_res; // front-panel test result
  logic [7:0] resp_buf [4]; // response text, newline included
  logic [1:0] resp_last; // index of the newline
  logic [1:0] resp_idx; // next character to send
  logic [15:0] acc; // mask parser accumulator
  logic [4:0] radix; // current parser radix
  logic hash_seen; // '#' waits for a radix letter
  logic key_meta; // first synchroniser stage
  logic key_sync; // second stage, safe to read
  logic key_prev; // for edge detection
  logic [31:0] fpan_cnt; // front-panel wait counter
  logic take; // command accepted this cycle
  logic mss; // master summary status
  logic [4:0] dval; // parsed digit value
  logic resp_load; // load a result answer
  logic [7:0] resp_val; // numeric answer 0..255
  logic resp_neg; // answer is -1
  logic [sst_pkg::NUM_CARDS-1:0] sel_mask; // decoded card mask

  // ==========================================================
  // status byte
  // only mav and esb sit below bit 6
  assign mss = |({esb_i, state == ST_RESP} & {sre[sst_pkg::ESB_BIT], sre[sst_pkg::MAV_BIT]});
  always_comb
  begin
    status_summary_byte_o = 8'h00;
    status_summary_byte_o[sst_pkg::MAV_BIT] = (state == ST_RESP);
    status_summary_byte_o[sst_pkg::ESB_BIT] = esb_i;
    status_summary_byte_o[sst_pkg::MSS_BIT] = mss;
  end

  // ==========================================================
  // command acceptance
  // busy states stall commands, keeping order
  assign cmd_ready_o = (state == ST_IDLE);
  assign take = cmd_valid_i && cmd_ready_o;
  assign sel_mask = card_mask(cmd_i.card, cmd_i.op != sst_pkg::OP_CARD_STATE_Q);

  // ==========================================================
  // key synchroniser and edge detect
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      key_meta <= 1'b0;
      key_sync <= 1'b0;
      key_prev <= 1'b0;
    end
    else
    begin
      key_meta <= key_i;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  // ==========================================================
  // enable-mask text parser: decimal by default, #B, #Q, #H prefixes
  assign dval = digit_val(param_char_i, radix);
  always_ff @(posedge clk_i)
  begin
    if (reset_i || (take && cmd_i.op == sst_pkg::OP_SRE_SET))
    begin
      acc <= 16'h0000;
      radix <= 5'd10;
      hash_seen <= 1'b0;
    end
    else if (param_valid_i)
    begin
      if (param_char_i == sst_pkg::CH_HASH)
        hash_seen <= 1'b1;
      else if (hash_seen)
      begin
        // radix letter; unknown letters keep decimal
        hash_seen <= 1'b0;
        unique case (param_char_i)
          sst_pkg::CH_B: radix <= 5'd2;
          sst_pkg::CH_Q: radix <= 5'd8;
          sst_pkg::CH_H: radix <= 5'd16;
          default: radix <= 5'd10;
        endcase
      end
      else if (dval != 5'h1f)
        // every radix lands in one binary value
        acc <= 16'(acc * 16'(radix) + 16'(dval));
    end
  end

  // ==========================================================
  // enable mask register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sre <= sst_pkg::SRE_RESET;
    else if (take && cmd_i.op == sst_pkg::OP_SRE_SET)
      sre <= acc[7:0] & sst_pkg::SRE_WRITABLE;
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= ST_IDLE;
      cmd_q <= '0;
      fpan_cnt <= 32'h0000_0000;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (take)
          begin
            cmd_q <= cmd_i;
            fpan_cnt <= 32'h0000_0000;
            unique case (cmd_i.op)
              sst_pkg::OP_STB_Q, sst_pkg::OP_SRE_Q, sst_pkg::OP_FRAME_STATE_Q:
                state <= ST_RESP;
              sst_pkg::OP_CARD_STATE_Q:
                state <= (sel_mask != '0) ? ST_RESP : ST_IDLE;
              sst_pkg::OP_WAI:
                state <= ST_WAIT_OPC;
              sst_pkg::OP_TST_Q:
                state <= ST_TEST;
              sst_pkg::OP_CARD_EXEC_Q:
                state <= (sel_mask != '0) ? ST_TEST : ST_IDLE;
              sst_pkg::OP_FRAME_EXEC_Q:
                state <= cmd_i.frame_fpan ? ST_FPAN : ST_TEST;
              default:
                state <= ST_IDLE;
            endcase
          end
        end
        ST_WAIT_OPC:
        begin
          if (opc_i)
            state <= ST_IDLE;
        end
        ST_TEST:
        begin
          if (test_done_i)
            state <= ST_RESP;
        end
        ST_FPAN:
        begin
          fpan_cnt <= fpan_cnt + 32'h0000_0001;
          // a key edge or the time limit ends the wait
          if ((key_sync && !key_prev) || fpan_cnt >= 32'(FPAN_TIMEOUT - 1))
            state <= ST_RESP;
        end
        ST_RESP:
        begin
          if (resp_ready_i && resp_idx == resp_last)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // test engine start and device side effects
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      test_start_o <= 1'b0;
      test_o <= '0;
      inst_reset_o <= 1'b0;
      card_cpon_o <= 1'b0;
      card_cpon_mask_o <= '0;
      cmd_error_o <= 1'b0;
    end
    else
    begin
      test_start_o <= 1'b0;
      inst_reset_o <= 1'b0;
      card_cpon_o <= 1'b0;
      cmd_error_o <= 1'b0;
      if (take)
      begin
        unique case (cmd_i.op)
          sst_pkg::OP_TST_Q:
          begin
            test_start_o <= 1'b1;
            test_o <= '{kind: sst_pkg::KIND_SELF, cards: '1};
          end
          sst_pkg::OP_CARD_EXEC_Q:
          begin
            test_start_o <= (sel_mask != '0);
            test_o <= '{kind: sst_pkg::KIND_CARD, cards: sel_mask};
          end
          sst_pkg::OP_FRAME_EXEC_Q:
          begin
            test_start_o <= !cmd_i.frame_fpan; // front panel runs here
            test_o <= '{kind: sst_pkg::KIND_CTRL, cards: '0};
          end
          default:
          begin
          end
        endcase
        if ((cmd_i.op == sst_pkg::OP_CARD_CLEAR || cmd_i.op == sst_pkg::OP_CARD_EXEC_Q
             || cmd_i.op == sst_pkg::OP_CARD_STATE_Q) && sel_mask == '0)
          cmd_error_o <= 1'b1;
      end
      if (state == ST_TEST && test_done_i)
      begin
        if (cmd_q.op == sst_pkg::OP_CARD_EXEC_Q)
        begin
          card_cpon_o <= 1'b1;
          card_cpon_mask_o <= test_o.cards;
        end
        else
        begin
          // self and controller tests end in reset
          inst_reset_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // stored results; instrument reset leaves them alone
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      card_res <= '{default: sst_pkg::RES_NONE};
      ctrl_res <= sst_pkg::RES_NONE;
      fpan_res <= sst_pkg::RES_NONE;
    end
    else
    begin
      for (int i = 0; i < sst_pkg::NUM_CARDS; i++)
      begin
        if (take && cmd_i.op == sst_pkg::OP_CARD_CLEAR && sel_mask[i])
          card_res[i] <= sst_pkg::RES_NONE;
        else if (state == ST_TEST && test_done_i && cmd_q.op == sst_pkg::OP_CARD_EXEC_Q
                 && test_o.cards[i])
          card_res[i] <= card_fail_i[i] ? sst_pkg::RES_FAIL : sst_pkg::RES_PASS;
      end
      if (take && cmd_i.op == sst_pkg::OP_FRAME_CLEAR)
      begin
        if (cmd_i.frame_fpan)
          fpan_res <= sst_pkg::RES_NONE;
        else
          ctrl_res <= sst_pkg::RES_NONE;
      end
      if (state == ST_TEST && test_done_i && cmd_q.op == sst_pkg::OP_FRAME_EXEC_Q)
        ctrl_res <= test_fail_i ? sst_pkg::RES_FAIL : sst_pkg::RES_PASS;
      if (state == ST_FPAN && key_sync && !key_prev)
        fpan_res <= sst_pkg::RES_PASS;
      else if (state == ST_FPAN && fpan_cnt >= 32'(FPAN_TIMEOUT - 1))
        fpan_res <= sst_pkg::RES_FAIL;
    end
  end

  // ==========================================================
  // answer value selection
  always_comb
  begin
    resp_load = 1'b0;
    resp_val = 8'h00;
    resp_neg = 1'b0;
    if (take)
    begin
      unique case (cmd_i.op)
        sst_pkg::OP_STB_Q:
        begin
          resp_load = 1'b1;
          // mav is set once answering starts
          resp_val = {1'b0, (sre[sst_pkg::MAV_BIT] | (esb_i & sre[sst_pkg::ESB_BIT])),
                      esb_i, 1'b1, 4'h0};
        end
        sst_pkg::OP_SRE_Q:
        begin
          resp_load = 1'b1;
          resp_val = sre;
        end
        sst_pkg::OP_CARD_STATE_Q:
        begin
          resp_load = (sel_mask != '0);
          for (int i = 0; i < sst_pkg::NUM_CARDS; i++)
          begin
            if (sel_mask[i])
            begin
              resp_neg = (card_res[i] == sst_pkg::RES_NONE);
              resp_val = {7'h00, card_res[i] == sst_pkg::RES_FAIL};
            end
          end
        end
        sst_pkg::OP_FRAME_STATE_Q:
        begin
          resp_load = 1'b1;
          resp_neg = ((cmd_i.frame_fpan ? fpan_res : ctrl_res) == sst_pkg::RES_NONE);
          resp_val = {7'h00, (cmd_i.frame_fpan ? fpan_res : ctrl_res) == sst_pkg::RES_FAIL};
        end
        default:
        begin
        end
      endcase
    end
    else if (state == ST_TEST && test_done_i)
    begin
      resp_load = 1'b1;
      if (cmd_q.op == sst_pkg::OP_CARD_EXEC_Q)
        resp_val = {7'h00, |(card_fail_i & test_o.cards)};
      else
        resp_val = {7'h00, test_fail_i};
    end
    else if (state == ST_FPAN && key_sync && !key_prev)
      resp_load = 1'b1; // pass answers 0
    else if (state == ST_FPAN && fpan_cnt >= 32'(FPAN_TIMEOUT - 1))
    begin
      resp_load = 1'b1;
      resp_val = 8'h01;
    end
  end

  // ==========================================================
  // response text: decimal digits, then newline flagged as end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      resp_buf <= '{default: 8'h00};
      resp_last <= 2'h0;
      resp_idx <= 2'h0;
    end
    else if (resp_load)
    begin
      resp_idx <= 2'h0;
      if (resp_neg)
      begin
        resp_buf <= '{sst_pkg::CH_MINUS, 8'h31, sst_pkg::CH_NL, 8'h00};
        resp_last <= 2'h2;
      end
      else if (resp_val >= 8'd100)
      begin
        resp_buf <= '{sst_pkg::CH_0 + resp_val / 8'd100, sst_pkg::CH_0 + (resp_val / 8'd10) % 8'd10,
                      sst_pkg::CH_0 + resp_val % 8'd10, sst_pkg::CH_NL};
        resp_last <= 2'h3;
      end
      else if (resp_val >= 8'd10)
      begin
        resp_buf <= '{sst_pkg::CH_0 + resp_val / 8'd10, sst_pkg::CH_0 + resp_val % 8'd10,
                      sst_pkg::CH_NL, 8'h00};
        resp_last <= 2'h2;
      end
      else
      begin
        resp_buf <= '{sst_pkg::CH_0 + resp_val, sst_pkg::CH_NL, 8'h00, 8'h00};
        resp_last <= 2'h1;
      end
    end
    else if (state == ST_RESP && resp_ready_i)
      resp_idx <= resp_idx + 2'h1;
  end

  // ==========================================================
  // response port
  assign resp_valid_o = (state == ST_RESP);
  assign resp_char_o = resp_buf[resp_idx];
  assign resp_end_o = (state == ST_RESP) && (resp_idx == resp_last);

endmodule : sst_core

// >>> verif/sst_core_sva.sv
/*
  port checker for the status and self-test block.
  assumes a bind onto sst_core.
*/
`timescale 1ns/100ps
// ==========================================================
// checker
module sst_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire sst_pkg::sst_cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire logic resp_valid_o,
  input wire logic [7:0] resp_char_o,
  input wire logic resp_end_o,
  input wire logic resp_ready_i,
  input wire logic esb_i,
  input wire logic test_start_o,
  input wire sst_pkg::sst_test_t test_o,
  input wire logic test_done_i,
  input wire logic inst_reset_o,
  input wire logic card_cpon_o,
  input wire logic [sst_pkg::NUM_CARDS-1:0] card_cpon_mask_o,
  input wire logic [7:0] status_summary_byte_o,
  input wire logic cmd_error_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic take; // command accepted at this edge
  logic card_op; // card clear or card test command
  assign take = cmd_valid_i && cmd_ready_o;
  assign card_op = cmd_i.op inside {sst_pkg::OP_CARD_CLEAR, sst_pkg::OP_CARD_EXEC_Q};
  unused_zero_a: assert property (status_summary_byte_o[3:0] == 4'h0 && !status_summary_byte_o[7])
    else $error("unused bit set");
  esb_mirror_a: assert property (status_summary_byte_o[5] == esb_i)
    else $error("esb bit mismatch");
  mss_quiet_a: assert property (status_summary_byte_o[5:4] == 2'h0 |-> !status_summary_byte_o[6])
    else $error("stray summary bit");
  query_digit_a: assert property (take && cmd_i.op == sst_pkg::OP_STB_Q
    |=> resp_valid_o && resp_char_o inside {[sst_pkg::CH_0:sst_pkg::CH_9]})
    else $error("answer not a digit");
  end_newline_a: assert property (resp_valid_o && resp_end_o |-> resp_char_o == sst_pkg::CH_NL)
    else $error("end marker without newline");
  resp_hold_a: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_char_o))
    else $error("answer char changed");
  self_start_a: assert property (take && cmd_i.op == sst_pkg::OP_TST_Q
    |=> test_start_o && test_o.kind == sst_pkg::KIND_SELF)
    else $error("self test not started");
  all_cards_a: assert property (take && cmd_i.op == sst_pkg::OP_CARD_EXEC_Q && cmd_i.card == 3'h0
    |=> test_start_o && test_o.cards == 4'hf)
    else $error("all-card test mask wrong");
  bad_card_a: assert property (take && card_op && cmd_i.card > sst_pkg::CARD_MAX
    |=> cmd_error_o && !test_start_o)
    else $error("bad card selector not refused");
  reset_after_a: assert property (test_done_i && !cmd_ready_o && test_o.kind != sst_pkg::KIND_CARD
    |=> inst_reset_o)
    else $error("no instrument reset after test");
  cpon_after_a: assert property (test_done_i && !cmd_ready_o && test_o.kind == sst_pkg::KIND_CARD
    |=> card_cpon_o && card_cpon_mask_o == $past(test_o.cards))
    else $error("no power-on request");
  cover property (take && cmd_i.op == sst_pkg::OP_FRAME_EXEC_Q);
  cover property (cmd_error_o);
  cover property (card_cpon_o);
endmodule : sst_chk

bind sst_core sst_chk sst_chk_inst (.clk_i, .reset_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
  .resp_valid_o, .resp_char_o, .resp_end_o, .resp_ready_i, .esb_i, .test_start_o, .test_o,
  .test_done_i, .inst_reset_o, .card_cpon_o, .card_cpon_mask_o, .status_summary_byte_o,
  .cmd_error_o);

// >>> verif/sst_host_model.sv
/*
  host reader: gathers answer characters into lines.
  assumes lines of at most eight characters.
*/
`timescale 1ns/100ps
// ==========================================================
// host model
module sst_host_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic slow_i, // stall every other cycle
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_char_i,
  input wire logic resp_end_i,
  output logic resp_ready_o,
  output logic [63:0] line_o, // last line, newline included
  output logic line_done_o // one cycle after the end character
);
  logic fresh; // next character starts a new line
  // ready toggles when slow to test stalls
  always_ff @(posedge clk_i)
    if (reset_i)
      resp_ready_o <= 1'b0;
    else
      resp_ready_o <= slow_i ? !resp_ready_o : 1'b1;
  // gather characters until the end marker
  always_ff @(posedge clk_i)
  begin
    line_done_o <= 1'b0;
    if (reset_i)
      fresh <= 1'b1;
    else if (resp_valid_i && resp_ready_o)
    begin
      line_o <= fresh ? {56'h0, resp_char_i} : {line_o[55:0], resp_char_i};
      fresh <= resp_end_i;
      line_done_o <= resp_end_i;
    end
  end
endmodule : sst_host_model

// >>> verif/tb_status_and_selftest_commands.sv
/*
  testbench for the status and self-test block.
  assumes the host model and an engine stand-in.
*/
`timescale 1ns/100ps
module tb_status_and_selftest_commands;
  logic clk_i, reset_i, cmd_valid_i, cmd_ready_o, param_valid_i, resp_valid_o, resp_end_o;
  logic resp_ready_i, esb_i, opc_i, key_i, test_start_o, test_done_i, test_fail_i;
  logic inst_reset_o, card_cpon_o, cmd_error_o, slow, key_arm, eng_fail, line_done;
  logic [7:0] param_char_i, resp_char_o, status_summary_byte_o;
  logic [3:0] card_fail_i, card_cpon_mask_o, eng_cards;
  logic [63:0] line;
  sst_pkg::sst_cmd_t cmd_i;
  sst_pkg::sst_test_t test_o;
  int fail_count, samples_checked, n_rst, n_cpon, n_err;
  // short key timeout keeps the run brief
  sst_core #(.FPAN_TIMEOUT(50)) sst_core_inst (.clk_i, .reset_i, .cmd_valid_i, .cmd_i,
    .cmd_ready_o, .param_valid_i, .param_char_i, .resp_valid_o, .resp_char_o, .resp_end_o,
    .resp_ready_i, .esb_i, .opc_i, .key_i, .test_start_o, .test_o, .test_done_i, .test_fail_i,
    .card_fail_i, .inst_reset_o, .card_cpon_o, .card_cpon_mask_o, .status_summary_byte_o,
    .cmd_error_o);
  sst_host_model sst_host_model_inst (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow),
    .resp_valid_i(resp_valid_o), .resp_char_i(resp_char_o), .resp_end_i(resp_end_o),
    .resp_ready_o(resp_ready_i), .line_o(line), .line_done_o(line_done));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // engine stand-in: verdict after three cycles
  always @(posedge clk_i)
    if (test_start_o === 1'b1)
    begin
      repeat (3) @(posedge clk_i);
      test_done_i <= 1'b1;
      test_fail_i <= eng_fail;
      card_fail_i <= eng_cards;
      @(posedge clk_i);
      test_done_i <= 1'b0;
    end
  // one key press during the front-panel test
  always @(posedge clk_i)
    if (key_arm && cmd_ready_o === 1'b0)
    begin
      key_arm <= 1'b0;
      repeat (4) @(posedge clk_i);
      key_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      key_i <= 1'b0;
    end
  // count request and error pulses
  always @(posedge clk_i)
  begin
    n_rst <= n_rst + int'(inst_reset_o === 1'b1);
    n_cpon <= n_cpon + int'(card_cpon_o === 1'b1);
    n_err <= n_err + int'(cmd_error_o === 1'b1);
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // hold a command until taken
  task automatic send(input sst_pkg::sst_op_t op, input logic [2:0] c, input logic f);
    int n;
    n = 0;
    cmd_i <= '{op, c, f};
    cmd_valid_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (cmd_ready_o !== 1'b1 && n < 400);
    cmd_valid_i <= 1'b0;
    if (cmd_ready_o !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    @(posedge clk_i); // a next call must not re-raise valid in this step
  endtask : send
  // query and compare the whole answer line
  task automatic ask(input sst_pkg::sst_op_t op, input logic [2:0] c, input logic f,
                     input string exp);
    logic [63:0] e;
    int n;
    e = '0;
    for (int i = 0; i < exp.len(); i++) e = {e[55:0], exp[i]};
    send(op, c, f);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (line_done !== 1'b1 && n < 300);
    if (line_done !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    check(line, {e[55:0], sst_pkg::CH_NL});
  endtask : ask
  // mask text first, then the set command
  task automatic sre(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      param_valid_i <= 1'b1;
      param_char_i <= s[i];
      @(posedge clk_i);
    end
    param_valid_i <= 1'b0;
    send(sst_pkg::OP_SRE_SET, 3'h0, 1'b0);
  endtask : sre
  initial
  begin
    string forms [4] = '{"48", "#B110000", "#Q60", "#H30"};
    fail_count = 0;
    samples_checked = 0;
    n_rst = 0;
    n_cpon = 0;
    n_err = 0;
    reset_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    param_valid_i = 1'b0;
    param_char_i = 8'h00;
    esb_i = 1'b0;
    opc_i = 1'b1;
    key_i = 1'b0;
    test_done_i = 1'b0;
    test_fail_i = 1'b0;
    card_fail_i = 4'h0;
    slow = 1'b0;
    key_arm = 1'b0;
    eng_fail = 1'b0;
    eng_cards = 4'h0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    ask(sst_pkg::OP_STB_Q, 3'h0, 1'b0, "16");
    esb_i <= 1'b1;
    ask(sst_pkg::OP_STB_Q, 3'h0, 1'b0, "48");
    for (int i = 0; i < 4; i++)
    begin
      sre(forms[i]);
      ask(sst_pkg::OP_SRE_Q, 3'h0, 1'b0, "48");
      ask(sst_pkg::OP_STB_Q, 3'h0, 1'b0, "112");
    end
    esb_i <= 1'b0;
    ask(sst_pkg::OP_STB_Q, 3'h0, 1'b0, "80");
    opc_i <= 1'b0;
    send(sst_pkg::OP_WAI, 3'h0, 1'b0);
    repeat (6) @(posedge clk_i);
    check({63'h0, cmd_ready_o}, 64'h0);
    opc_i <= 1'b1;
    eng_fail <= 1'b1;
    ask(sst_pkg::OP_TST_Q, 3'h0, 1'b0, "1");
    check(64'(n_rst), 64'h1);
    slow <= 1'b1;
    ask(sst_pkg::OP_CARD_STATE_Q, 3'h2, 1'b0, "-1");
    eng_cards <= 4'h4;
    // relay adapter fitted before card tests
    ask(sst_pkg::OP_CARD_EXEC_Q, 3'h0, 1'b0, "1");
    check(64'(n_cpon), 64'h1);
    ask(sst_pkg::OP_CARD_STATE_Q, 3'h3, 1'b0, "1");
    ask(sst_pkg::OP_CARD_STATE_Q, 3'h1, 1'b0, "0");
    ask(sst_pkg::OP_CARD_EXEC_Q, 3'h1, 1'b0, "0");
    send(sst_pkg::OP_CARD_CLEAR, 3'h3, 1'b0);
    ask(sst_pkg::OP_CARD_STATE_Q, 3'h3, 1'b0, "-1");
    ask(sst_pkg::OP_CARD_STATE_Q, 3'h1, 1'b0, "0");
    send(sst_pkg::OP_CARD_STATE_Q, 3'h0, 1'b0);
    send(sst_pkg::OP_CARD_EXEC_Q, 3'h5, 1'b0);
    repeat (3) @(posedge clk_i);
    check(64'(n_err), 64'h2);
    slow <= 1'b0;
    ask(sst_pkg::OP_FRAME_STATE_Q, 3'h0, 1'b0, "-1");
    eng_fail <= 1'b0;
    ask(sst_pkg::OP_FRAME_EXEC_Q, 3'h0, 1'b0, "0");
    check(64'(n_rst), 64'h2);
    key_arm <= 1'b1;
    ask(sst_pkg::OP_FRAME_EXEC_Q, 3'h0, 1'b1, "0");
    ask(sst_pkg::OP_FRAME_EXEC_Q, 3'h0, 1'b1, "1");
    check(64'(n_rst), 64'h2);
    ask(sst_pkg::OP_FRAME_STATE_Q, 3'h0, 1'b1, "1");
    send(sst_pkg::OP_FRAME_CLEAR, 3'h0, 1'b1);
    ask(sst_pkg::OP_FRAME_STATE_Q, 3'h0, 1'b1, "-1");
    ask(sst_pkg::OP_FRAME_STATE_Q, 3'h0, 1'b0, "0");
    close_out();
  end
endmodule : tb_status_and_selftest_commands
